/* File: motor_param_pkg.sv */
// constants, widths and the code expansion function for the motor parameter decoder
// assumes codes arrive from configuration registers in the core clock domain
// How it works
// - phase resistance arrives as 7 bits: upper three shift, lower four mantissa.
// - one step of linear resistance equals 9.67 milliohms phase to centre tap.
// - linear resistance is the mantissa shifted left by the shift field.
// - resistance code 0x7F decodes to 1920, about 18.6 ohms.
// - back-EMF constant arrives as 7 bits: 3-bit shift, 4-bit mantissa, shifted.
// - linear back-EMF equals volts per hertz times a weight of 1090.
// - back-EMF code 0x7F decodes to 1920, 1760 mV/Hz.
// - back-EMF code 0x01 decodes to 1, 0.92 mV/Hz.
`default_nettype none
package motor_param_pkg;

    // *****************************
    // field layout
    // *****************************
    localparam int CODE_W = 7;
    localparam int EXP_W = 3;
    localparam int MANT_W = 4;
    localparam int LIN_W = 11;
    localparam int EXP_MSB = 6;
    localparam int EXP_LSB = 4;
    localparam int MANT_MSB = 3;
    localparam int MANT_LSB = 0;

    // *****************************
    // scaling and limits
    // *****************************
    // one linear resistance step in micro-ohms
    localparam int RES_LSB_MICROOHM = 9670;
    // linear back-EMF per volt-per-hertz
    localparam int BEMF_WEIGHT = 1090;
    localparam logic [LIN_W-1:0] LINEAR_MAX = 11'h780;
    localparam logic [LIN_W-1:0] RES_LINEAR_MIN = 11'h003;
    localparam logic [MANT_W-1:0] MANT_CANON_MIN = 4'h8;

    // *****************************
    // reset values
    // *****************************
    localparam logic [CODE_W-1:0] CODE_RST = 7'h00;
    localparam logic [LIN_W-1:0] LINEAR_RST = 11'h000;

    typedef logic [CODE_W-1:0] param_code_t;
    typedef logic [LIN_W-1:0] param_linear_t;

    // mantissa shifted left by exponent
    function automatic param_linear_t expand_code(input param_code_t code);
        param_linear_t mant;
        mant = LIN_W'(code[MANT_MSB:MANT_LSB]);
        return mant << code[EXP_MSB:EXP_LSB];
    endfunction

    // a nonzero exponent with a small mantissa has a shorter twin encoding
    function automatic logic is_noncanon(input param_code_t code);
        return (code[EXP_MSB:EXP_LSB] != 3'h0) && (code[MANT_MSB:MANT_LSB] < MANT_CANON_MIN);
    endfunction

endpackage
`default_nettype wire

/* File: param_code_if.sv */
// carrier between the top and one code expander
// assumes a single core clock; the carrier is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface param_code_if;
    import motor_param_pkg::*;
    param_code_t code;
    param_linear_t linear;
    logic noncanon;
    modport src (output code, input linear, input noncanon);
    modport dec (input code, output linear, output noncanon);
endinterface
`default_nettype wire

/* File: param_code_expander.sv */
// expands one 7-bit shift/mantissa code into its linear value
// assumes the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module param_code_expander (
    param_code_if.dec link
);
    import motor_param_pkg::*;

    always_comb begin
        link.linear = expand_code(link.code);
        link.noncanon = is_noncanon(link.code);
    end
endmodule
`default_nettype wire

/* File: motor_param_code_decoder.sv */
// top of the motor parameter decoder: latches both codes on a load strobe
// and presents registered linear values and status flags to the control core
// assumes codes and strobe are synchronous to CLK_I
`timescale 1ns/1ps
`default_nettype none
module motor_param_code_decoder (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire motor_param_pkg::param_code_t PHASE_RES_CODE_I,
    input wire motor_param_pkg::param_code_t BEMF_CONST_CODE_I,
    input wire logic CODE_LOAD_I,
    output logic [motor_param_pkg::LIN_W-1:0] PHASE_RES_LINEAR_O,
    output logic [motor_param_pkg::LIN_W-1:0] BEMF_CONST_LINEAR_O,
    output logic PARAM_VALID_O,
    output logic RES_BELOW_MIN_O,
    output logic RES_NONCANON_O,
    output logic BEMF_NONCANON_O
);
    import motor_param_pkg::*;

    // *****************************
    // code fields
    // *****************************
    logic [EXP_W-1:0] phase_res_exponent;
    logic [MANT_W-1:0] phase_res_mantissa;
    logic [EXP_W-1:0] bemf_const_exponent;
    logic [MANT_W-1:0] bemf_const_mantissa;

    // upper three bits shift, lower four bits mantissa
    assign phase_res_exponent = PHASE_RES_CODE_I[EXP_MSB:EXP_LSB];
    assign phase_res_mantissa = PHASE_RES_CODE_I[MANT_MSB:MANT_LSB];
    assign bemf_const_exponent = BEMF_CONST_CODE_I[EXP_MSB:EXP_LSB];
    assign bemf_const_mantissa = BEMF_CONST_CODE_I[MANT_MSB:MANT_LSB];

    // *****************************
    // expanders, one per code
    // *****************************
    localparam int SLOT_RES = 0;
    localparam int SLOT_BEMF = 1;
    localparam int SLOT_N = 2;

    param_code_t code_in [SLOT_N];
    param_linear_t lin [SLOT_N];
    logic nc [SLOT_N];

    assign code_in[SLOT_RES] = {phase_res_exponent, phase_res_mantissa};
    assign code_in[SLOT_BEMF] = {bemf_const_exponent, bemf_const_mantissa};

    // small mantissas with a nonzero shift still expand literally; flags report them
    genvar gi;
    generate
        for (gi = 0; gi < SLOT_N; gi++) begin : g_exp
            param_code_if link_if ();
            param_code_expander u_exp (
                .link(link_if)
            );
            assign link_if.code = code_in[gi];
            assign lin[gi] = link_if.linear;
            assign nc[gi] = link_if.noncanon;
        end
    endgenerate

    // *****************************
    // load qualification
    // *****************************
    // reset wins over load, so a load in a reset cycle is dropped
    logic take;
    assign take = CODE_LOAD_I && !SYS_RST_I;

    // *****************************
    // resistance group
    // *****************************
    param_linear_t res_lin;
    logic res_low;
    logic res_nc;
    param_linear_t next_res_lin;
    logic next_res_low;
    logic next_res_nc;

    always_comb begin
        next_res_lin = res_lin;
        next_res_low = res_low;
        next_res_nc = res_nc;
        // values held from one load to the next
        if (take) begin
            next_res_lin = lin[SLOT_RES];
            next_res_low = (lin[SLOT_RES] < RES_LINEAR_MIN);
            next_res_nc = nc[SLOT_RES];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            res_lin <= LINEAR_RST;
            res_low <= 1'b0;
            res_nc <= 1'b0;
        end else begin
            res_lin <= next_res_lin;
            res_low <= next_res_low;
            res_nc <= next_res_nc;
        end
    end

    // *****************************
    // back-EMF group
    // *****************************
    param_linear_t bemf_lin;
    logic bemf_nc;
    param_linear_t next_bemf_lin;
    logic next_bemf_nc;

    always_comb begin
        next_bemf_lin = bemf_lin;
        next_bemf_nc = bemf_nc;
        if (take) begin
            next_bemf_lin = lin[SLOT_BEMF];
            next_bemf_nc = nc[SLOT_BEMF];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            bemf_lin <= LINEAR_RST;
            bemf_nc <= 1'b0;
        end else begin
            bemf_lin <= next_bemf_lin;
            bemf_nc <= next_bemf_nc;
        end
    end

    // *****************************
    // status group
    // *****************************
    logic valid;
    logic next_valid;

    always_comb begin
        next_valid = valid;
        // only reset clears it, so the core can wait for it before starting
        if (take) begin
            next_valid = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            valid <= 1'b0;
        end else begin
            valid <= next_valid;
        end
    end

    // *****************************
    // outputs, each straight from its flop
    // *****************************
    assign PHASE_RES_LINEAR_O = res_lin;
    assign BEMF_CONST_LINEAR_O = bemf_lin;
    assign PARAM_VALID_O = valid;
    assign RES_BELOW_MIN_O = res_low;
    assign RES_NONCANON_O = res_nc;
    assign BEMF_NONCANON_O = bemf_nc;
endmodule
`default_nettype wire

/* File: motor_param_props.sv */
// checks on the decoder top ports
// assumes a bind onto the top module
`timescale 1ns/1ps
`default_nettype none
module motor_param_props (
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    input wire motor_param_pkg::param_code_t PHASE_RES_CODE_I,
    input wire motor_param_pkg::param_code_t BEMF_CONST_CODE_I,
    input wire logic CODE_LOAD_I,
    input wire logic [10:0] PHASE_RES_LINEAR_O,
    input wire logic [10:0] BEMF_CONST_LINEAR_O,
    input wire logic PARAM_VALID_O,
    input wire logic RES_BELOW_MIN_O,
    input wire logic RES_NONCANON_O,
    input wire logic BEMF_NONCANON_O
);
    import motor_param_pkg::*;
    // ***
    // checks
    // ***
    logic ld;
    logic [10:0] rx;
    logic [10:0] bx;
    logic bnc;
    logic rnc;
    assign ld = CODE_LOAD_I && !SYS_RST_I;
    assign rnc = PHASE_RES_CODE_I[6:4] != 3'h0 && PHASE_RES_CODE_I[3:0] < 4'h8;
    assign rx = 11'(PHASE_RES_CODE_I[3:0]) << PHASE_RES_CODE_I[6:4];
    assign bx = 11'(BEMF_CONST_CODE_I[3:0]) << BEMF_CONST_CODE_I[6:4];
    assign bnc = BEMF_CONST_CODE_I[6:4] != 3'h0 && BEMF_CONST_CODE_I[3:0] < 4'h8;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (SYS_RST_I);
    property p_res; ld |=> PHASE_RES_LINEAR_O == $past(rx); endproperty
    a_res: assert property (p_res) else $error("res linear wrong");
    property p_bemf; ld |=> BEMF_CONST_LINEAR_O == $past(bx); endproperty
    a_bemf: assert property (p_bemf) else $error("bemf linear wrong");
    property p_hold; !ld |=> $stable(PHASE_RES_LINEAR_O) && $stable(BEMF_CONST_LINEAR_O);
    endproperty
    a_hold: assert property (p_hold) else $error("value moved");
    property p_rmax; ld && PHASE_RES_CODE_I == 7'h7F |=> PHASE_RES_LINEAR_O == 11'h780;
    endproperty
    a_rmax: assert property (p_rmax) else $error("res max wrong");
    property p_bmax; ld && BEMF_CONST_CODE_I == 7'h7F |=> BEMF_CONST_LINEAR_O == 11'h780;
    endproperty
    a_bmax: assert property (p_bmax) else $error("bemf max wrong");
    property p_bone; ld && BEMF_CONST_CODE_I == 7'h01 |=> BEMF_CONST_LINEAR_O == 11'h001;
    endproperty
    a_bone: assert property (p_bone) else $error("bemf one wrong");
    property p_min; ld |=> RES_BELOW_MIN_O == ($past(rx) < 11'h003); endproperty
    a_min: assert property (p_min) else $error("below min wrong");
    property p_ncan; ld |=> BEMF_NONCANON_O == $past(bnc); endproperty
    a_ncan: assert property (p_ncan) else $error("noncanon wrong");
    property p_rncan; ld |=> RES_NONCANON_O == $past(rnc); endproperty
    a_rncan: assert property (p_rncan) else $error("res noncanon wrong");
    property p_valid; ld |=> PARAM_VALID_O; endproperty
    a_valid: assert property (p_valid) else $error("valid not raised");
    property p_vhold; PARAM_VALID_O |=> PARAM_VALID_O; endproperty
    a_vhold: assert property (p_vhold) else $error("valid dropped");
    property p_fhold; !ld |=> $stable(PARAM_VALID_O) && $stable(RES_BELOW_MIN_O) &&
        $stable(RES_NONCANON_O) && $stable(BEMF_NONCANON_O);
    endproperty
    a_fhold: assert property (p_fhold) else $error("flag moved");
endmodule
bind motor_param_code_decoder motor_param_props props_u (.CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I),
    .PHASE_RES_CODE_I(PHASE_RES_CODE_I), .BEMF_CONST_CODE_I(BEMF_CONST_CODE_I),
    .CODE_LOAD_I(CODE_LOAD_I), .PHASE_RES_LINEAR_O(PHASE_RES_LINEAR_O),
    .BEMF_CONST_LINEAR_O(BEMF_CONST_LINEAR_O), .PARAM_VALID_O(PARAM_VALID_O),
    .RES_BELOW_MIN_O(RES_BELOW_MIN_O), .RES_NONCANON_O(RES_NONCANON_O),
    .BEMF_NONCANON_O(BEMF_NONCANON_O));
`default_nettype wire

/* File: motor_param_code_decoder_tb_top.sv */
// bench for the decoder with a code model
// assumes the checker file is compiled too
`timescale 1ns/1ps
`default_nettype none
module motor_param_code_decoder_tb_top;
    import motor_param_pkg::*;
    // ***
    // bench
    // ***
    logic clk, rst, ld, pv, bm, rn, bn;
    param_code_t rc, bc;
    logic [10:0] rl, bl;
    int err_count = 0, check_count = 0, er, eb, ev;
    int tbl[$] = '{16'h7F01, 16'h037F, 16'h0211, 16'h1108, 16'h0F00};
    always #12.5 clk = ~clk;
    motor_param_code_decoder dut_u (.CLK_I(clk), .SYS_RST_I(rst), .PHASE_RES_CODE_I(rc),
        .BEMF_CONST_CODE_I(bc), .CODE_LOAD_I(ld), .PHASE_RES_LINEAR_O(rl),
        .BEMF_CONST_LINEAR_O(bl), .PARAM_VALID_O(pv), .RES_BELOW_MIN_O(bm),
        .RES_NONCANON_O(rn), .BEMF_NONCANON_O(bn));
    function automatic int lin(input int c);
        return (c & 15) << (c >> 4);
    endfunction
    function automatic int nc(input int c);
        return int'((c >> 4) != 0 && (c & 15) < 8);
    endfunction
    task automatic chk(input string n, input logic [10:0] s, input int e);
        check_count++;
        if (s !== 11'(e)) begin
            $display("MISMATCH %s exp %0h got %0h", n, e, s);
            err_count++;
        end
    endtask
    task automatic step(input int r, input int b, input bit l);
        rc = 7'(r);
        bc = 7'(b);
        ld = l;
        @(posedge clk);
        #1;
        if (l && !rst) begin
            er = r;
            eb = b;
            ev = 1;
        end
        chk("res", rl, lin(er));
        chk("bemf", bl, lin(eb));
        chk("valid", pv, ev);
        chk("below", bm, ev && lin(er) < 3);
        chk("res_nc", rn, nc(er));
        chk("bemf_nc", bn, nc(eb));
    endtask
    // reset wins over load, so loads are offered throughout
    task automatic do_reset();
        rst = 1'b1;
        er = 0;
        eb = 0;
        ev = 0;
        repeat (10) step(127, 127, 1'b1);
        rst = 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge clk);
        err_count++;
        end_of_test();
    end
    initial begin
        {clk, rst, ld, rc, bc} = '0;
        void'($urandom(32'h36936800));
        do_reset();
        foreach (tbl[i]) step(tbl[i] >> 8, tbl[i] & 16'hFF, 1'b1);
        step(0, 0, 1'b0);
        $display("test directed done");
        repeat (300) step($urandom & 127, $urandom & 127, 1'($urandom));
        $display("test random done");
        do_reset();
        step(5, 5, 1'b0);
        do_reset();
        step(7'h49, 7'h21, 1'b1);
        $display("test reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
